// ### agvr_gain_hold.sv
// ============================================================
// Purpose: Holds the gain code that an amplifier really uses
// Assumes: zero_seen is already synchronised to core_clk
// Notes:   A deferred change waits for the zero crossing of its channel
// ============================================================
`timescale 1ns/1ns
module agvr_gain_hold #(
	parameter int                 WIDTH      = 5,
	parameter logic [WIDTH-1:0]   RESET_CODE = '0
) (
	input  wire logic             core_clk,
	input  wire logic             srst,
	input  wire logic             core_ce,
	input  wire logic [WIDTH-1:0] written_code,
	input  wire logic             apply,
	input  wire logic             zero_wait,
	input  wire logic             zero_seen,
	output logic      [WIDTH-1:0] applied_code,
	output logic                  pending
);

	logic [WIDTH-1:0] target_code;

	// ============================================================
	// Deferred target and its pending flag
	always_ff @(posedge core_clk) begin
		if (srst) begin
			target_code <= RESET_CODE;
			pending     <= 1'b0;
		end else if (core_ce) begin
			if (apply && zero_wait) begin
				// Wait for crossing, a newer apply replaces the target
				target_code <= written_code;
				pending     <= 1'b1;
			end else if (apply) begin
				pending <= 1'b0;
			end else if (pending && zero_seen) begin
				pending <= 1'b0;
			end
		end
	end

	// ============================================================
	// Gain in use by the amplifier
	always_ff @(posedge core_clk) begin
		if (srst) begin
			applied_code <= RESET_CODE;
		end else if (core_ce) begin
			if (apply && !zero_wait) begin
				// Immediate change when zero wait is off
				applied_code <= written_code;
			end else if (!apply && pending && zero_seen) begin
				applied_code <= target_code;
			end
		end
	end

endmodule : agvr_gain_hold

// ### agvr_pkg.sv
// ============================================================
// Purpose: Constants and carrier types for the gain and volume register bank
// Assumes: 16-bit register words on an 8-bit register address
// Notes:   Every offset, field position and reset value is named once here
// ============================================================
package agvr_pkg;

	// ============================================================
	// Bus geometry
	localparam int ADDR_WIDTH = 8;
	localparam int DATA_WIDTH = 16;

	// ============================================================
	// Register offsets
	localparam logic [7:0] LEFT_INPUT_PAIR1_GAIN_OFFSET  = 8'h18;
	localparam logic [7:0] LEFT_INPUT_PAIR2_GAIN_OFFSET  = 8'h19;
	localparam logic [7:0] RIGHT_INPUT_PAIR1_GAIN_OFFSET = 8'h1a;
	localparam logic [7:0] RIGHT_INPUT_PAIR2_GAIN_OFFSET = 8'h1b;
	localparam logic [7:0] LEFT_HEADPHONE_GAIN_OFFSET    = 8'h1c;
	localparam logic [7:0] RIGHT_HEADPHONE_GAIN_OFFSET   = 8'h1d;
	localparam logic [7:0] LINE_OUTPUT_GAIN_OFFSET       = 8'h1e;
	localparam logic [7:0] GAIN_PENDING_STATUS_OFFSET    = 8'h40;

	// ============================================================
	// Field positions
	localparam int APPLY_STROBE_BIT      = 8;
	localparam int INPUT_SILENCE_BIT     = 7;
	localparam int INPUT_ZERO_WAIT_BIT   = 6;
	localparam int INPUT_CODE_WIDTH      = 5;
	localparam int HP_ZERO_WAIT_BIT      = 7;
	localparam int HP_UNSILENCE_BIT      = 6;
	localparam int HP_CODE_WIDTH         = 6;
	localparam int LINE_NEG_SILENCE_BIT  = 6;
	localparam int LINE_POS_SILENCE_BIT  = 5;
	localparam int LINE_ATTENUATE_BIT    = 4;

	// ============================================================
	// Reset values
	localparam logic [4:0] INPUT_CODE_RESET      = 5'h0b;
	localparam logic       INPUT_SILENCE_RESET   = 1'h1;
	localparam logic       INPUT_ZERO_WAIT_RESET = 1'h0;
	localparam logic [5:0] HP_CODE_RESET         = 6'h2d;
	localparam logic       HP_UNSILENCE_RESET    = 1'h1;
	localparam logic       HP_ZERO_WAIT_RESET    = 1'h0;
	localparam logic       LINE_SILENCE_RESET    = 1'h1;
	localparam logic       LINE_ATTENUATE_RESET  = 1'h0;

	// ============================================================
	// Carrier types
	typedef struct packed {
		logic       silence;
		logic       zero_wait;
		logic [4:0] gain_code;
	} agvr_input_ctl_type;

	typedef struct packed {
		logic       zero_wait;
		logic       unsilence;
		logic [5:0] gain_code;
	} agvr_hp_ctl_type;

	typedef struct packed {
		logic neg_silence;
		logic pos_silence;
		logic attenuate;
	} agvr_line_ctl_type;

	localparam agvr_input_ctl_type INPUT_CTL_RESET = '{INPUT_SILENCE_RESET, INPUT_ZERO_WAIT_RESET, INPUT_CODE_RESET};
	localparam agvr_hp_ctl_type    HP_CTL_RESET    = '{HP_ZERO_WAIT_RESET, HP_UNSILENCE_RESET, HP_CODE_RESET};
	localparam agvr_line_ctl_type  LINE_CTL_RESET  = '{LINE_SILENCE_RESET, LINE_SILENCE_RESET, LINE_ATTENUATE_RESET};

endpackage : agvr_pkg

// ### agvr_regs.sv
// ============================================================
// Purpose: Gain, mute and zero-cross register bank for input, headphone and line stages
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes:   Zero-cross indications arrive from the analogue side and are synchronised
// Behaviour
// - Input gain code is five bits 4:0, resets to 0_1011.
// - Apply bit 8 on either pair-one register updates both pair-one gains together.
// - Apply bit 8 on either pair-two register updates both pair-two gains together.
// - Input silence bit 7 mutes when one, resets to one.
// - Zero wait clear, its reset value, applies a gain change immediately.
// - Zero wait bit 6 set defers a gain change until zero crossing.
// - Headphone gain code bits 5:0, minus 57 to plus 6 dB, resets 10_1101.
// - Apply bit 8 on either headphone register updates both headphone gains together.
// - Headphone zero wait bit 7 enables zero-cross changes, resets to zero.
// - Headphone unsilence bit 6, zero mutes, resets to one.
// - Line output negative and positive silence bits 6 and 5 reset to one.
// - Line output attenuate bit 4 selects minus 6 dB, resets to zero.
// ============================================================
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns
module agvr_regs (
	input  wire logic                             core_clk,
	input  wire logic                             srst,
	input  wire logic                             core_ce,
	// Register port
	input  wire logic [agvr_pkg::ADDR_WIDTH-1:0]  reg_addr,
	input  wire logic [agvr_pkg::DATA_WIDTH-1:0]  reg_wdata,
	input  wire logic                             reg_write,
	input  wire logic                             reg_read,
	output logic      [agvr_pkg::DATA_WIDTH-1:0]  reg_rdata,
	// Zero crossings from the analogue side, asynchronous
	input  wire logic [3:0]                       input_zero_cross,
	input  wire logic [1:0]                       headphone_zero_cross,
	// Input amplifier controls, index 0 pair1 left, 1 pair1 right, 2 pair2 left, 3 pair2 right
	output logic      [3:0][4:0]                  input_gain_stage,
	output logic      [3:0]                       input_silence,
	// Headphone amplifier controls
	output logic      [5:0]                       headphone_left_gain_stage,
	output logic      [5:0]                       headphone_right_gain_stage,
	output logic                                  headphone_left_unsilence,
	output logic                                  headphone_right_unsilence,
	// Line output controls
	output logic                                  line_output_neg_silence,
	output logic                                  line_output_pos_silence,
	output logic                                  line_output_attenuate,
	// Deferred change status, inputs in 3:0, headphones in 5:4
	output logic      [5:0]                       gain_pending
);

	// ============================================================
	// Field unpacking and readback, used for each register of a kind
	function automatic agvr_pkg::agvr_input_ctl_type input_from_word(
		input logic [agvr_pkg::DATA_WIDTH-1:0] word
	);
		agvr_pkg::agvr_input_ctl_type ctl;
		ctl.silence   = word[agvr_pkg::INPUT_SILENCE_BIT];
		ctl.zero_wait = word[agvr_pkg::INPUT_ZERO_WAIT_BIT];
		ctl.gain_code = word[agvr_pkg::INPUT_CODE_WIDTH-1:0];
		return ctl;
	endfunction : input_from_word

	function automatic logic [agvr_pkg::DATA_WIDTH-1:0] input_to_word(
		input agvr_pkg::agvr_input_ctl_type ctl
	);
		logic [agvr_pkg::DATA_WIDTH-1:0] word;
		word = '0;
		word[agvr_pkg::INPUT_SILENCE_BIT]          = ctl.silence;
		word[agvr_pkg::INPUT_ZERO_WAIT_BIT]        = ctl.zero_wait;
		word[agvr_pkg::INPUT_CODE_WIDTH-1:0]       = ctl.gain_code;
		return word;
	endfunction : input_to_word

	function automatic agvr_pkg::agvr_hp_ctl_type hp_from_word(
		input logic [agvr_pkg::DATA_WIDTH-1:0] word
	);
		agvr_pkg::agvr_hp_ctl_type ctl;
		ctl.zero_wait = word[agvr_pkg::HP_ZERO_WAIT_BIT];
		ctl.unsilence = word[agvr_pkg::HP_UNSILENCE_BIT];
		ctl.gain_code = word[agvr_pkg::HP_CODE_WIDTH-1:0];
		return ctl;
	endfunction : hp_from_word

	function automatic logic [agvr_pkg::DATA_WIDTH-1:0] hp_to_word(
		input agvr_pkg::agvr_hp_ctl_type ctl
	);
		logic [agvr_pkg::DATA_WIDTH-1:0] word;
		word = '0;
		word[agvr_pkg::HP_ZERO_WAIT_BIT]        = ctl.zero_wait;
		word[agvr_pkg::HP_UNSILENCE_BIT]        = ctl.unsilence;
		word[agvr_pkg::HP_CODE_WIDTH-1:0]       = ctl.gain_code;
		return word;
	endfunction : hp_to_word

	// Write strobe with an address match
	function automatic logic write_hit(
		input logic                            write,
		input logic [agvr_pkg::ADDR_WIDTH-1:0] addr,
		input logic [agvr_pkg::ADDR_WIDTH-1:0] offset
	);
		return write && (addr == offset);
	endfunction : write_hit

	// ============================================================
	// Stored settings
	agvr_pkg::agvr_input_ctl_type [3:0] input_ctl;
	agvr_pkg::agvr_input_ctl_type [3:0] next_input_ctl;
	agvr_pkg::agvr_hp_ctl_type    [1:0] hp_ctl;
	agvr_pkg::agvr_hp_ctl_type    [1:0] next_hp_ctl;
	agvr_pkg::agvr_line_ctl_type        line_ctl;

	logic [3:0] input_hit;
	logic [1:0] hp_hit;
	logic       line_hit;
	logic       pair1_apply;
	logic       pair2_apply;
	logic       hp_apply;
	logic [3:0] input_apply;
	logic [3:0] input_zero_meta;
	logic [3:0] input_zero_sync;
	logic [1:0] hp_zero_meta;
	logic [1:0] hp_zero_sync;
	logic [5:0] hp_stage_code [1:0];

	// ============================================================
	// Address decode of writes
	assign input_hit[0] = write_hit(reg_write, reg_addr, agvr_pkg::LEFT_INPUT_PAIR1_GAIN_OFFSET);
	assign input_hit[1] = write_hit(reg_write, reg_addr, agvr_pkg::RIGHT_INPUT_PAIR1_GAIN_OFFSET);
	assign input_hit[2] = write_hit(reg_write, reg_addr, agvr_pkg::LEFT_INPUT_PAIR2_GAIN_OFFSET);
	assign input_hit[3] = write_hit(reg_write, reg_addr, agvr_pkg::RIGHT_INPUT_PAIR2_GAIN_OFFSET);
	assign hp_hit[0]    = write_hit(reg_write, reg_addr, agvr_pkg::LEFT_HEADPHONE_GAIN_OFFSET);
	assign hp_hit[1]    = write_hit(reg_write, reg_addr, agvr_pkg::RIGHT_HEADPHONE_GAIN_OFFSET);
	assign line_hit     = write_hit(reg_write, reg_addr, agvr_pkg::LINE_OUTPUT_GAIN_OFFSET);

	// ============================================================
	// Apply strobes, a written zero leaves the gains alone
	// strobe only
	assign pair1_apply = (input_hit[0] || input_hit[1]) && reg_wdata[agvr_pkg::APPLY_STROBE_BIT];
	assign pair2_apply = (input_hit[2] || input_hit[3]) && reg_wdata[agvr_pkg::APPLY_STROBE_BIT];
	assign hp_apply    = (hp_hit[0] || hp_hit[1]) && reg_wdata[agvr_pkg::APPLY_STROBE_BIT];
	assign input_apply = {pair2_apply, pair2_apply, pair1_apply, pair1_apply};

	// ============================================================
	// Next settings, so an apply in the same write uses the new code
	always_comb begin
		next_input_ctl = input_ctl;
		next_hp_ctl    = hp_ctl;
		for (int i = 0; i < 4; i++) begin
			if (input_hit[i]) begin
				next_input_ctl[i] = input_from_word(reg_wdata);
			end
		end
		for (int i = 0; i < 2; i++) begin
			if (hp_hit[i]) begin
				next_hp_ctl[i] = hp_from_word(reg_wdata);
			end
		end
	end

	// ============================================================
	// Input and headphone setting registers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			input_ctl <= {4{agvr_pkg::INPUT_CTL_RESET}};
			hp_ctl    <= {2{agvr_pkg::HP_CTL_RESET}};
		end else if (core_ce) begin
			input_ctl <= next_input_ctl;
			hp_ctl    <= next_hp_ctl;
		end
	end

	// ============================================================
	// Line output register
	always_ff @(posedge core_clk) begin
		if (srst) begin
			line_ctl <= agvr_pkg::LINE_CTL_RESET;
		end else if (core_ce && line_hit) begin
			line_ctl.neg_silence <= reg_wdata[agvr_pkg::LINE_NEG_SILENCE_BIT];
			line_ctl.pos_silence <= reg_wdata[agvr_pkg::LINE_POS_SILENCE_BIT];
			line_ctl.attenuate   <= reg_wdata[agvr_pkg::LINE_ATTENUATE_BIT];
		end
	end

	// ============================================================
	// Zero-cross synchronisers, two stages each
	always_ff @(posedge core_clk) begin
		if (srst) begin
			input_zero_meta <= 4'h0;
			input_zero_sync <= 4'h0;
			hp_zero_meta    <= 2'h0;
			hp_zero_sync    <= 2'h0;
		end else if (core_ce) begin
			input_zero_meta <= input_zero_cross;
			input_zero_sync <= input_zero_meta;
			hp_zero_meta    <= headphone_zero_cross;
			hp_zero_sync    <= hp_zero_meta;
		end
	end

	// ============================================================
	// Gain in use per input amplifier
	for (genvar g = 0; g < 4; g++) begin : g_input_hold
		agvr_gain_hold #(
			.WIDTH      (agvr_pkg::INPUT_CODE_WIDTH),
			.RESET_CODE (agvr_pkg::INPUT_CODE_RESET)
		) u_hold (
			.core_clk     (core_clk),
			.srst         (srst),
			.core_ce      (core_ce),
			.written_code (next_input_ctl[g].gain_code),
			.apply        (input_apply[g]),
			.zero_wait    (next_input_ctl[g].zero_wait),
			.zero_seen    (input_zero_sync[g]),
			.applied_code (input_gain_stage[g]),
			.pending      (gain_pending[g])
		);
	end

	// ============================================================
	// Gain in use per headphone amplifier
	for (genvar g = 0; g < 2; g++) begin : g_hp_hold
		agvr_gain_hold #(
			.WIDTH      (agvr_pkg::HP_CODE_WIDTH),
			.RESET_CODE (agvr_pkg::HP_CODE_RESET)
		) u_hold (
			.core_clk     (core_clk),
			.srst         (srst),
			.core_ce      (core_ce),
			.written_code (next_hp_ctl[g].gain_code),
			.apply        (hp_apply),
			.zero_wait    (next_hp_ctl[g].zero_wait),
			.zero_seen    (hp_zero_sync[g]),
			.applied_code (hp_stage_code[g]),
			.pending      (gain_pending[4 + g])
		);
	end

	// ============================================================
	// Amplifier control outputs, mutes act at once
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			input_silence[i] = input_ctl[i].silence;
		end
	end
	assign headphone_left_gain_stage  = hp_stage_code[0];
	assign headphone_right_gain_stage = hp_stage_code[1];
	assign headphone_left_unsilence   = hp_ctl[0].unsilence;
	assign headphone_right_unsilence  = hp_ctl[1].unsilence;
	assign line_output_neg_silence    = line_ctl.neg_silence;
	assign line_output_pos_silence    = line_ctl.pos_silence;
	assign line_output_attenuate      = line_ctl.attenuate;

	// ============================================================
	// Read data, one cycle after the read strobe, zero elsewhere
	always_ff @(posedge core_clk) begin
		if (srst) begin
			reg_rdata <= 16'h0000;
		end else if (core_ce) begin
			reg_rdata <= 16'h0000;
			if (reg_read) begin
				unique case (reg_addr)
					agvr_pkg::LEFT_INPUT_PAIR1_GAIN_OFFSET:  reg_rdata <= input_to_word(input_ctl[0]);
					agvr_pkg::RIGHT_INPUT_PAIR1_GAIN_OFFSET: reg_rdata <= input_to_word(input_ctl[1]);
					agvr_pkg::LEFT_INPUT_PAIR2_GAIN_OFFSET:  reg_rdata <= input_to_word(input_ctl[2]);
					agvr_pkg::RIGHT_INPUT_PAIR2_GAIN_OFFSET: reg_rdata <= input_to_word(input_ctl[3]);
					agvr_pkg::LEFT_HEADPHONE_GAIN_OFFSET:    reg_rdata <= hp_to_word(hp_ctl[0]);
					agvr_pkg::RIGHT_HEADPHONE_GAIN_OFFSET:   reg_rdata <= hp_to_word(hp_ctl[1]);
					agvr_pkg::LINE_OUTPUT_GAIN_OFFSET: begin
						reg_rdata[agvr_pkg::LINE_NEG_SILENCE_BIT] <= line_ctl.neg_silence;
						reg_rdata[agvr_pkg::LINE_POS_SILENCE_BIT] <= line_ctl.pos_silence;
						reg_rdata[agvr_pkg::LINE_ATTENUATE_BIT]   <= line_ctl.attenuate;
					end
					agvr_pkg::GAIN_PENDING_STATUS_OFFSET:    reg_rdata <= {10'h000, gain_pending};
					default:                                 reg_rdata <= 16'h0000;
				endcase
			end
		end
	end

endmodule : agvr_regs

// ### agvr_regs_sva.sv
// ============================================================
// Purpose: Port checks for the gain and volume register bank
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bound to agvr_regs below the module
// ============================================================
`timescale 1ns/1ns
module agvr_regs_sva (
	input wire logic             core_clk,
	input wire logic             srst,
	input wire logic             core_ce,
	input wire logic [7:0]       reg_addr,
	input wire logic [15:0]      reg_wdata,
	input wire logic             reg_write,
	input wire logic             reg_read,
	input wire logic [15:0]      reg_rdata,
	input wire logic [3:0]       input_zero_cross,
	input wire logic [1:0]       headphone_zero_cross,
	input wire logic [3:0][4:0]  input_gain_stage,
	input wire logic [3:0]       input_silence,
	input wire logic [5:0]       headphone_left_gain_stage,
	input wire logic [5:0]       headphone_right_gain_stage,
	input wire logic             headphone_left_unsilence,
	input wire logic             headphone_right_unsilence,
	input wire logic             line_output_neg_silence,
	input wire logic             line_output_pos_silence,
	input wire logic             line_output_attenuate,
	input wire logic [5:0]       gain_pending
);
	// ============================================================
	// Clocking and reset for every property
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	// ============================================================
	// Reset values seen on the first edge after release
	chk_reset_gains: assert property ($fell(srst) |-> input_gain_stage == {4{5'h0b}}
		&& headphone_left_gain_stage == 6'h2d && headphone_right_gain_stage == 6'h2d)
		else $error("gain stages not at reset codes");
	// Line output, input silence and headphone unsilence fields follow the written word
	chk_line_fields: assert property (reg_write && core_ce && reg_addr == 8'h1e
		|=> {line_output_neg_silence, line_output_pos_silence, line_output_attenuate} == $past(reg_wdata[6:4]))
		else $error("line output fields differ from written word");
	chk_input_mute: assert property (reg_write && core_ce && reg_addr == 8'h18
		|=> input_silence[0] == $past(reg_wdata[7])) else $error("input silence not updated");
	chk_hp_mute: assert property (reg_write && core_ce && reg_addr == 8'h1c
		|=> headphone_left_unsilence == $past(reg_wdata[6])) else $error("headphone unsilence not updated");
	// Immediate apply when the zero wait is clear
	chk_apply_now: assert property (reg_write && core_ce && reg_addr == 8'h18 && reg_wdata[8] && !reg_wdata[6]
		|=> input_gain_stage[0] == $past(reg_wdata[4:0])) else $error("input gain not applied at once");
	chk_hp_apply: assert property (reg_write && core_ce && reg_addr == 8'h1d && reg_wdata[8] && !reg_wdata[7]
		|=> headphone_right_gain_stage == $past(reg_wdata[5:0])) else $error("headphone gain not applied");
	// Without an apply strobe or a pending input change nothing reaches the input stages
	chk_no_strobe: assert property (reg_write && !reg_wdata[8] && gain_pending[3:0] == 4'h0
		|=> $stable(input_gain_stage)) else $error("gain changed without apply");
	// Deferred change waits, then clears within four cycles of a held crossing
	chk_defer_pend: assert property (reg_write && core_ce && reg_addr == 8'h18 && reg_wdata[8] && reg_wdata[6]
		&& !input_zero_cross[0] && !$past(input_zero_cross[0]) && !$past(input_zero_cross[0], 2)
		|=> gain_pending[0]) else $error("deferred change not pending");
	chk_defer_clear: assert property ((gain_pending[0] && $rose(input_zero_cross[0]))
		##0 (core_ce && !reg_write && input_zero_cross[0])[*4] |-> !gain_pending[0])
		else $error("pending change not applied at zero crossing");
	// Read data: strobe bit always zero, bus idle between answers
	chk_strobe_read: assert property (reg_read && core_ce |=> reg_rdata[8] == 1'b0)
		else $error("apply bit read back as one");
	chk_rdata_idle: assert property (!reg_read && core_ce |=> reg_rdata == 16'h0000)
		else $error("read data not idle");
endmodule : agvr_regs_sva

bind agvr_regs agvr_regs_sva agvr_regs_sva_inst (.core_clk(core_clk), .srst(srst), .core_ce(core_ce),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.input_zero_cross(input_zero_cross), .headphone_zero_cross(headphone_zero_cross),
	.input_gain_stage(input_gain_stage), .input_silence(input_silence),
	.headphone_left_gain_stage(headphone_left_gain_stage), .headphone_right_gain_stage(headphone_right_gain_stage),
	.headphone_left_unsilence(headphone_left_unsilence), .headphone_right_unsilence(headphone_right_unsilence),
	.line_output_neg_silence(line_output_neg_silence), .line_output_pos_silence(line_output_pos_silence),
	.line_output_attenuate(line_output_attenuate), .gain_pending(gain_pending));

// ### test_agvr_regs.sv
// ============================================================
// Purpose: Self-checking bench for the gain and volume register bank
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Zero crossings are driven as levels on the clock edge
// ============================================================
`timescale 1ns/1ns
module test_agvr_regs;
	logic            core_clk;
	logic            srst;
	logic            core_ce;
	logic [7:0]      reg_addr;
	logic [15:0]     reg_wdata;
	logic            reg_write;
	logic            reg_read;
	logic [15:0]     reg_rdata;
	logic [3:0]      input_zero_cross;
	logic [1:0]      headphone_zero_cross;
	logic [3:0][4:0] input_gain_stage;
	logic [3:0]      input_silence;
	logic [5:0]      hp_left;
	logic [5:0]      hp_right;
	logic            hp_left_on;
	logic            hp_right_on;
	logic            line_neg;
	logic            line_pos;
	logic            line_att;
	logic [5:0]      gain_pending;
	int              fail_count;
	int              compares;
	logic [15:0]     reset_words [7] = '{16'h008b, 16'h008b, 16'h008b, 16'h008b, 16'h006d, 16'h006d, 16'h0060};
	logic [15:0]     line_words [4] = '{16'h0000, 16'h0050, 16'h0020, 16'hffff};

	agvr_regs agvr_regs_inst (.core_clk(core_clk), .srst(srst), .core_ce(core_ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.input_zero_cross(input_zero_cross), .headphone_zero_cross(headphone_zero_cross),
		.input_gain_stage(input_gain_stage), .input_silence(input_silence),
		.headphone_left_gain_stage(hp_left), .headphone_right_gain_stage(hp_right),
		.headphone_left_unsilence(hp_left_on), .headphone_right_unsilence(hp_right_on),
		.line_output_neg_silence(line_neg), .line_output_pos_silence(line_pos),
		.line_output_attenuate(line_att), .gain_pending(gain_pending));

	// Clock at 125 MHz
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// Compare one value and count it
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
		#1;
	endtask : wr

	// One-cycle read strobe, data checked in the following cycle
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1;
		check(reg_rdata, e);
	endtask : rd

	// Print the counts and the verdict
	task automatic summarize();
		$display("checks %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize

	// Watchdog against a hang
	initial begin
		repeat (5000) @(posedge core_clk);
		fail_count++;
		summarize();
	end

	// Main sequence
	initial begin
		fail_count = 0;
		compares = 0;
		srst = 1'b1;
		core_ce = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_write = 1'b0;
		reg_read = 1'b0;
		input_zero_cross = 4'h0;
		headphone_zero_cross = 2'h0;
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		for (int i = 0; i < 7; i++)
			rd(8'h18 + 8'(i), reset_words[i]);
		for (int i = 0; i < 4; i++)
			check(16'(input_gain_stage[i]), 16'h000b);
		check(16'(input_silence), 16'h000f);
		check(16'({hp_left, hp_right}), 16'h0b6d);
		check(16'({hp_left_on, hp_right_on, line_neg, line_pos, line_att}), 16'h001e);
		wr(8'h30, 16'hffff);
		rd(8'h30, 16'h0000);
		// pair one apply from the left register
		wr(8'h1a, 16'h0005);
		check(16'(input_gain_stage[1]), 16'h000b);
		wr(8'h18, 16'h0110);
		check(16'({input_gain_stage[0], input_gain_stage[1]}), 16'h0205);
		check(16'(input_silence), 16'h000c);
		rd(8'h18, 16'h0010);
		// pair two apply from the right register
		wr(8'h19, 16'h0003);
		wr(8'h1b, 16'h011f);
		check(16'({input_gain_stage[2], input_gain_stage[3]}), 16'h007f);
		wr(8'h18, 16'h0141);
		check(16'({gain_pending[0], input_gain_stage[0]}), 16'h0030);
		rd(8'h40, 16'h0001);
		@(posedge core_clk) input_zero_cross <= 4'h1;
		repeat (4) @(posedge core_clk);
		#1;
		check(16'({gain_pending[0], input_gain_stage[0]}), 16'h0001);
		@(posedge core_clk) input_zero_cross <= 4'h0;
		// headphone pair apply, full scale and zero
		wr(8'h1c, 16'h003f);
		check(16'({hp_left_on, hp_left}), 16'h002d);
		wr(8'h1d, 16'h0100);
		check(16'({hp_left, hp_right}), 16'h0fc0);
		check(16'({hp_left_on, hp_right_on}), 16'h0000);
		wr(8'h1d, 16'h01c5);
		check(16'({gain_pending[5], hp_right}), 16'h0040);
		@(posedge core_clk) headphone_zero_cross <= 2'h2;
		repeat (4) @(posedge core_clk);
		#1;
		check(16'({gain_pending[5], hp_right}), 16'h0005);
		@(posedge core_clk) headphone_zero_cross <= 2'h0;
		rd(8'h1d, 16'h00c5);
		for (int i = 0; i < 4; i++) begin
			wr(8'h1e, line_words[i]);
			check(16'({line_neg, line_pos, line_att}), 16'(line_words[i][6:4]));
			rd(8'h1e, line_words[i] & 16'h0070);
		end
		// Clock enable low: a write is not taken
		@(posedge core_clk) core_ce <= 1'b0;
		wr(8'h1e, 16'h0000);
		check(16'({line_neg, line_pos, line_att}), 16'h0007);
		@(posedge core_clk) core_ce <= 1'b1;
		summarize();
	end
endmodule : test_agvr_regs
